// ==== bench/emmap_asserts.sv ====
/* port checker of the mapper top: bus handshake, routing and break relations.
   assumes it is bound onto emmap_top and sees its ports only. */
`timescale 1ns/100ps
module emmap_asserts (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    input wire logic cpu_cycle_in,
    input wire logic cpu_write_in,
    input wire logic emem_sel_out,
    input wire logic emem_write_out,
    input wire logic target_sel_out,
    input wire logic target_write_out,
    input wire logic break_req_out,
    input wire logic lockup_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_req_new;
        $rose(avs_read_in || avs_write_in);
    endsequence
    sequence s_req_held;
        s_req_new ##1 (avs_read_in || avs_write_in);
    endsequence
    property p_wait_first;
        s_req_new |-> avs_waitrequest_out;
    endproperty
    property p_wait_answer;
        s_req_held |-> !avs_waitrequest_out;
    endproperty
    property p_sel_one;
        cpu_cycle_in |-> $onehot({emem_sel_out, target_sel_out});
    endproperty
    property p_emem_wr;
        emem_write_out |-> emem_sel_out && cpu_write_in && cpu_cycle_in;
    endproperty
    property p_tgt_wr;
        target_write_out |-> target_sel_out && cpu_write_in;
    endproperty
    property p_tgt_pass;
        cpu_cycle_in && cpu_write_in && target_sel_out |-> target_write_out;
    endproperty
    property p_brk_cause;
        $rose(break_req_out) |-> $past(cpu_cycle_in);
    endproperty
    property p_lock_hold;
        lockup_out |=> lockup_out;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("waitrequest low on first edge");
    a_wait_answer: assert property (p_wait_answer) else $error("waitrequest still high");
    a_sel_one: assert property (p_sel_one) else $error("access not routed to exactly one side");
    a_emem_wr: assert property (p_emem_wr) else $error("stray emulation memory write");
    a_tgt_wr: assert property (p_tgt_wr) else $error("stray target write");
    a_tgt_pass: assert property (p_tgt_pass) else $error("target write held back");
    a_brk_cause: assert property (p_brk_cause) else $error("break without a bus cycle");
    a_lock_hold: assert property (p_lock_hold) else $error("lockup released");
endmodule
bind emmap_top emmap_asserts emmap_asserts_inst (.mclk_in, .resetn_in, .avs_read_in, .avs_write_in,
    .avs_waitrequest_out, .cpu_cycle_in, .cpu_write_in, .emem_sel_out, .emem_write_out, .target_sel_out,
    .target_write_out, .break_req_out, .lockup_out);

// ==== bench/emmap_target_model.sv ====
/* target system model: answers each bus cycle with ready after a set number of wait cycles.
   assumes the processor bus cycle strobe; ready stays low outside cycles. */
`timescale 1ns/100ps
module emmap_target_model (
    input  wire logic       mclk_in,
    input  wire logic       resetn_in,
    input  wire logic       cycle_in,
    input  wire logic [3:0] wait_in,
    output logic            ready_out
);
    logic [3:0] cnt;
    // only answers cycles, never moves data into emulation memory itself
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt <= 4'h0;
        end else if (!cycle_in) begin
            cnt <= 4'h0;
        end else if (cnt != 4'hf) begin
            cnt <= cnt + 4'h1;
        end
    end
    assign ready_out = cycle_in && (cnt >= wait_in);
endmodule

// ==== bench/tb_emulation_memory_mapper.sv ====
/* self-checking bench of the mapper: drives avalon-mm and the processor bus, queues expectations.
   assumes hw/ on the include path and the target model beside it. */
`timescale 1ns/100ps
`include "emmap_regs.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin failures++; $display("mismatch %s exp %h seen %h", n, e, s); end end
module tb_emulation_memory_mapper;
    typedef struct {int k; logic [31:0] e; logic [31:0] m;} emmap_note_s;
    logic        mclk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic [7:0]  avs_address_in = 8'h00;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic [19:0] cpu_addr_in = 20'h0;
    logic        cpu_cycle_in = 1'b0;
    logic        cpu_write_in = 1'b0;
    logic        cpu_dma_in = 1'b0;
    logic        monitor_entry_in = 1'b0;
    logic        target_ready_in;
    logic        cpu_ready_out, emem_sel_out, emem_write_out, target_sel_out, target_write_out;
    logic        break_req_out, lockup_out, irq_out;
    logic [19:0] emem_addr_out;
    logic [3:0]  tgt_wait = 4'h0;
    logic [31:0] seed = 32'h0000_0034;
    int          failures = 0;
    int          total_checks = 0;
    emmap_note_s notes[$];
    emmap_note_s n;
    string       nm[6] = '{"route", "readdata", "break", "irq", "lockup", "emem_addr"};

    emmap_top #(.LOOP_CYC(50)) emmap_top_inst (.mclk_in, .resetn_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hf), .avs_readdata_out, .avs_waitrequest_out,
        .cpu_addr_in, .cpu_cycle_in, .cpu_write_in, .cpu_dma_in, .monitor_entry_in, .target_ready_in,
        .cpu_ready_out, .emem_sel_out, .emem_write_out, .emem_addr_out, .target_sel_out,
        .target_write_out, .break_req_out, .lockup_out, .irq_out);
    emmap_target_model emmap_target_model_inst (.mclk_in, .resetn_in, .cycle_in(cpu_cycle_in),
        .wait_in(tgt_wait), .ready_out(target_ready_in));

    initial begin
        forever #50 mclk_in = ~mclk_in;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] seen(int k);
        case (k)
            0: return {27'h0, emem_sel_out, emem_write_out, target_sel_out, target_write_out, cpu_ready_out};
            1: return avs_readdata_out;
            2: return {31'h0, break_req_out};
            3: return {31'h0, irq_out};
            4: return {31'h0, lockup_out};
            default: return {12'h0, emem_addr_out};
        endcase
    endfunction

    task automatic note(int k, logic [31:0] e, logic [31:0] m = 32'hffff_ffff);
        notes.push_back('{k, e, m});
    endtask

    // request held until the edge where waitrequest was already low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int c;
        @(posedge mclk_in);
        avs_read_in <= !wr;
        avs_write_in <= wr;
        avs_address_in <= a;
        avs_writedata_in <= d;
        c = 0;
        do begin
            @(negedge mclk_in);
            c++;
        end while (avs_waitrequest_out !== 1'b0 && c < 20);
        if (c >= 20) failures++;
        @(posedge mclk_in);
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
        bus(1'b0, a, 32'h0);
        note(1, e & m, m);
    endtask

    task automatic put(int i, logic [9:0] s, logic [9:0] e, emmap_pkg::emmap_type_e t, logic l);
        bus(1'b1, `EMMAP_SEL_OFS, i);
        bus(1'b1, `EMMAP_ENTRY_OFS, {7'h0, 1'b1, l, t, e, s});
    endtask

    // offset inside the page and the dma flag are random: decoding must ignore both
    task automatic cpu(input logic [9:0] pg, input logic wr, input logic [4:0] v, input logic b,
                       input logic [9:0] bp = 10'h000);
        logic [31:0] r;
        r = xs();
        @(posedge mclk_in);
        cpu_cycle_in <= 1'b1;
        cpu_write_in <= wr;
        cpu_addr_in <= {pg, r[9:0]};
        cpu_dma_in <= r[10];
        note(0, {27'h0, v});
        if (v[4]) note(5, {12'h0, bp, r[9:0]});
        @(posedge mclk_in);
        cpu_cycle_in <= 1'b0;
        note(2, {31'h0, b});
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(negedge mclk_in) begin
        while (notes.size() != 0) begin
            n = notes.pop_front();
            `CHK(nm[n.k], n.e, seen(n.k) & n.m)
        end
    end

    initial begin
        repeat (4000) @(posedge mclk_in);
        failures++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge mclk_in);
        resetn_in <= 1'b1;
        rd(`EMMAP_DEFAULT_OFS, 32'h2);
        rd(`EMMAP_CTRL_OFS, 32'h0);
        rd(8'h3c, 32'h0);
        cpu(10'h007, 1'b1, 5'b00111, 1'b0);
        put(0, 10'h000, 10'h000, emmap_pkg::EMMAP_EMUL_RAM, 1'b0);
        put(1, 10'h001, 10'h001, emmap_pkg::EMMAP_EMUL_ROM, 1'b0);
        put(2, 10'h002, 10'h003, emmap_pkg::EMMAP_TGT_RAM, 1'b0);
        put(3, 10'h004, 10'h004, emmap_pkg::EMMAP_TGT_ROM, 1'b0);
        put(4, 10'h005, 10'h005, emmap_pkg::EMMAP_GUARDED, 1'b0);
        put(5, 10'h006, 10'h006, emmap_pkg::EMMAP_EMUL_RAM, 1'b1);
        put(15, 10'h3ff, 10'h3ff, emmap_pkg::EMMAP_EMUL_RAM, 1'b0);
        rd(`EMMAP_STATUS_OFS, 32'h8, 32'h8);
        // blocks go out in map order: entries 0, 1, 5 and 15 get pages 0 to 3
        cpu(10'h000, 1'b1, 5'b11001, 1'b0);
        cpu(10'h001, 1'b1, 5'b10001, 1'b0, 10'h001);
        cpu(10'h002, 1'b1, 5'b00111, 1'b0);
        cpu(10'h003, 1'b0, 5'b00101, 1'b0);
        cpu(10'h004, 1'b1, 5'b00111, 1'b0);
        cpu(10'h005, 1'b0, 5'b00101, 1'b1);
        cpu(10'h005, 1'b1, 5'b00111, 1'b1);
        cpu(10'h3ff, 1'b0, 5'b10001, 1'b0, 10'h003);
        bus(1'b1, `EMMAP_CTRL_OFS, 32'h1);
        cpu(10'h001, 1'b1, 5'b10001, 1'b1, 10'h001);
        cpu(10'h004, 1'b1, 5'b00111, 1'b1);
        tgt_wait <= 4'h2;
        cpu(10'h006, 1'b0, 5'b10000, 1'b0, 10'h002);
        cpu(10'h000, 1'b0, 5'b10001, 1'b0);
        bus(1'b1, `EMMAP_DEFAULT_OFS, 32'h4);
        bus(1'b1, `EMMAP_DEFAULT_OFS, 32'h5);
        rd(`EMMAP_DEFAULT_OFS, 32'h4, 32'hf);
        // target space waits on the target ready, still low in the first cycle
        cpu(10'h008, 1'b0, 5'b00100, 1'b1);
        bus(1'b1, `EMMAP_DEFAULT_OFS, 32'h8);
        cpu(10'h008, 1'b0, 5'b10000, 1'b0, 10'h008);
        tgt_wait <= 4'h0;
        bus(1'b1, `EMMAP_IRQ_EN_OFS, 32'h0);
        bus(1'b1, `EMMAP_IRQ_CLR_OFS, 32'hf);
        rd(`EMMAP_STATUS_OFS, 32'h0, 32'h1);
        cpu(10'h005, 1'b0, 5'b00101, 1'b1);
        rd(`EMMAP_STATUS_OFS, 32'h1, 32'h1);
        note(3, 32'h0);
        bus(1'b1, `EMMAP_IRQ_EN_OFS, 32'h1);
        note(3, 32'h1);
        bus(1'b1, `EMMAP_IRQ_CLR_OFS, 32'h1);
        note(3, 32'h0);
        bus(1'b1, `EMMAP_DEFAULT_OFS, 32'h2);
        bus(1'b1, `EMMAP_MON_OFS, 32'h0000_0110);
        cpu(10'h040, 1'b0, 5'b10001, 1'b0);
        cpu(10'h043, 1'b1, 5'b11001, 1'b0, 10'h003);
        cpu(10'h044, 1'b0, 5'b00101, 1'b0);
        cpu(10'h005, 1'b0, 5'b00101, 1'b0);
        bus(1'b1, `EMMAP_DEFAULT_OFS, 32'h4);
        // each break re-enters the monitor, as a foreground monitor touching guarded space would
        for (int i = 0; i < `EMMAP_LOOP_LIMIT; i++) begin
            @(posedge mclk_in);
            monitor_entry_in <= 1'b1;
            @(posedge mclk_in);
            monitor_entry_in <= 1'b0;
            cpu(10'h100, 1'b0, 5'b00101, 1'b1);
        end
        repeat (2) @(posedge mclk_in);
        note(4, 32'h1);
        rd(`EMMAP_STATUS_OFS, 32'h4, 32'h4);
        repeat (2) @(posedge mclk_in);
        complete_run();
    end
endmodule

// ==== hw/emmap_cmp.sv ====
/*
 * one range comparator of the mapper.
 * assumes the entry is held by the instantiating module.
 */
`timescale 1ns/100ps
module emmap_cmp #(
    parameter int IDX = 0
) (
    input  emmap_pkg::emmap_entry_s entry_in,
    emmap_match_if.cmp              m
);
    // inclusive page bounds; ranges are whole 1 kbyte pages
    assign m.hit[IDX] = entry_in.valid && (m.page >= entry_in.start_page) && (m.page <= entry_in.end_page);
endmodule

// ==== hw/emmap_match_if.sv ====
/*
 * carries the page under test and each entry's match answer between the
 * mapper and its comparators.
 * assumes the 20-bit processor address in 1 kbyte pages.
 */
`timescale 1ns/100ps
interface emmap_match_if #(parameter int ENTRIES = 16);
    logic [9:0]         page;
    // each comparator drives its own bit, so this is a net
    wire  [ENTRIES-1:0] hit;
    modport mapper (output page, input hit);
    modport cmp    (input page, output hit);
endinterface

// ==== hw/emmap_pkg.sv ====
/*
 * types shared by the emulation memory mapper modules.
 * assumes nothing beyond a systemverilog compiler.
 */
package emmap_pkg;
    typedef enum logic [2:0] {
        EMMAP_EMUL_RAM  = 3'h0,
        EMMAP_EMUL_ROM  = 3'h1,
        EMMAP_TGT_RAM   = 3'h2,
        EMMAP_TGT_ROM   = 3'h3,
        EMMAP_GUARDED   = 3'h4
    } emmap_type_e;

    typedef struct packed {
        logic        valid;
        logic        lock;
        emmap_type_e kind;
        logic [9:0]  end_page;
        logic [9:0]  start_page;
    } emmap_entry_s;

    typedef enum logic [1:0] {
        EMMAP_MON_BACKGROUND = 2'h0,
        EMMAP_MON_FOREGROUND = 2'h1,
        EMMAP_MON_USER_FG    = 2'h2
    } emmap_mon_e;
endpackage

// ==== hw/emmap_regs.svh ====
/*
 * register offsets, field positions, reset values and timing counts of the
 * emulation memory mapper.
 * assumes a 32-bit avalon-mm slave with byte addresses, one word per register.
 */
`ifndef EMMAP_REGS_SVH
`define EMMAP_REGS_SVH

`define EMMAP_CTRL_OFS       8'h00
`define EMMAP_DEFAULT_OFS    8'h04
`define EMMAP_MON_OFS        8'h08
`define EMMAP_STATUS_OFS     8'h0c
`define EMMAP_IRQ_EN_OFS     8'h10
`define EMMAP_IRQ_CLR_OFS    8'h14
`define EMMAP_SEL_OFS        8'h18
`define EMMAP_ENTRY_OFS      8'h1c
`define EMMAP_ALLOC_OFS      8'h20
`define EMMAP_BREAK_OFS      8'h24

// ctrl fields
`define EMMAP_CTRL_ROMBRK    0
`define EMMAP_CTRL_CLRMAP    1
`define EMMAP_CTRL_RESET     32'h0000_0000

// default register: type in [2:0], lock in bit 3
`define EMMAP_DEF_LOCK       3
`define EMMAP_DEF_RESET      4'h2

// monitor register: base page (4 kbyte units) in [7:0], type [9:8], lock bit 10
`define EMMAP_MON_TYPE_LO    8
`define EMMAP_MON_LOCK       10

// entry register: start page [9:0], end page [19:10], type [22:20], lock 23, valid 24
`define EMMAP_ENT_END_LO     10
`define EMMAP_ENT_TYPE_LO    20
`define EMMAP_ENT_LOCK       23
`define EMMAP_ENT_VALID      24

// status bits
`define EMMAP_ST_GUARD       0
`define EMMAP_ST_ROMWR       1
`define EMMAP_ST_LOOP        2
`define EMMAP_ST_INVALID     3

// recurring-break window after monitor entry
`define EMMAP_LOOP_MS        10
`define EMMAP_CLK_KHZ        10000
`define EMMAP_LOOP_CYC       (`EMMAP_LOOP_MS * `EMMAP_CLK_KHZ)
`define EMMAP_LOOP_LIMIT     4

`endif

// ==== hw/emmap_top.sv ====
/*
 * emulation memory mapper: sorts each emulation processor access by address,
 * routes it to emulation memory or the target and raises monitor breaks.
 * assumes a 20-bit processor bus sampled on mclk_in and avalon-mm software access.
 */
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
// How it works
// - sixteen range entries, each with its own type and lock attribute.
// - ranges start and end on 1 kbyte pages; compare uses the page only.
// - emulation memory is 1 mbyte, handed out in blocks to emulation ranges.
// - on-chip dma cycles are decoded and served just like processor cycles.
// - five range types decide routing and breaks.
// - any access to guarded space raises a monitor break.
// - rom writes break only while break-on-rom-write is enabled.
// - writes to emulation rom never reach emulation memory.
// - writes to target rom or guarded still go out to the target.
// - unlocked emulation ranges ignore target ready.
// - unmatched addresses are target ram unless another default is set.
// - default type is configurable, with lock for emulation types.
// - map edits may reallocate blocks; contents flagged invalid afterwards.
// - breaks recurring within 10 ms of monitor entry latch a lockup.
// - foreground monitor clears the map and maps one 4 kbyte emulation range.
// - any monitor type change deletes all ranges.
`timescale 1ns/100ps
`include "emmap_regs.svh"
module emmap_top #(
    parameter int ENTRIES    = 16,
    parameter int LOOP_CYC   = `EMMAP_LOOP_CYC,
    parameter int EMEM_PAGES = 1024
) (
    input  wire logic        mclk_in,
    input  wire logic        resetn_in,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    // emulation processor bus (processor or its on-chip dma)
    input  wire logic [19:0] cpu_addr_in,
    input  wire logic        cpu_cycle_in,
    input  wire logic        cpu_write_in,
    input  wire logic        cpu_dma_in,
    input  wire logic        monitor_entry_in,
    input  wire logic        target_ready_in,
    output logic             cpu_ready_out,
    output logic             emem_sel_out,
    output logic             emem_write_out,
    output logic [19:0]      emem_addr_out,
    output logic             target_sel_out,
    output logic             target_write_out,
    output logic             break_req_out,
    output logic             lockup_out,
    output logic             irq_out
);
    // parameter values the logic cannot serve stop elaboration
    if (ENTRIES < 1 || ENTRIES > 16) begin : g_bad_entries
        $error("emmap_top: ENTRIES must be 1..16");
    end
    if (LOOP_CYC < 1) begin : g_bad_loop
        $error("emmap_top: LOOP_CYC must be positive");
    end
    if (EMEM_PAGES < 1 || EMEM_PAGES > 1024) begin : g_bad_pages
        $error("emmap_top: EMEM_PAGES must be 1..1024");
    end

    emmap_pkg::emmap_entry_s entry [ENTRIES];
    logic [9:0]              blk_base [ENTRIES];
    logic [3:0]              ctrl;
    logic [3:0]              dflt;
    logic [10:0]             mon;
    logic [3:0]              status;
    logic [3:0]              irq_en;
    logic [3:0]              sel;
    logic [31:0]             break_count;
    logic [31:0]             loop_timer;
    logic [2:0]              loop_hits;
    logic                    wr_ack;
    logic                    rd_ack;
    logic                    rom_brk;

    emmap_match_if #(.ENTRIES(ENTRIES)) m ();

    genvar gi;
    generate
        for (gi = 0; gi < ENTRIES; gi++) begin : g_cmp
            emmap_cmp #(.IDX(gi)) u_cmp (
                .entry_in (entry[gi]),
                .m        (m)
            );
        end
    endgenerate

    assign m.page = cpu_addr_in[19:10];
    assign rom_brk = ctrl[`EMMAP_CTRL_ROMBRK];

    // software bus: one wait state on every access gives registered read data
    logic acc;
    assign acc = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = acc & ~(wr_ack | rd_ack);

    // a write lands only at the edge where waitrequest is already low
    logic do_wr;
    assign do_wr = avs_write_in & wr_ack;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_ack <= 1'b0;
            rd_ack <= 1'b0;
        end else begin
            wr_ack <= avs_write_in & ~wr_ack;
            rd_ack <= avs_read_in & ~rd_ack;
        end
    end

    // decode, priority lowest entry number wins
    logic                    hit_any;
    emmap_pkg::emmap_type_e  kind;
    logic                    lock;
    logic [9:0]              emem_page;

    always_comb begin
        hit_any   = 1'b0;
        kind      = emmap_pkg::emmap_type_e'(dflt[2:0]);
        lock      = dflt[`EMMAP_DEF_LOCK];
        emem_page = m.page;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (m.hit[i]) begin
                hit_any   = 1'b1;
                kind      = entry[i].kind;
                lock      = entry[i].lock;
                emem_page = 10'(blk_base[i] + (m.page - entry[i].start_page));
            end
        end
    end

    logic is_emul;
    logic is_rom;
    logic guard_ev;
    logic romwr_ev;
    assign is_emul  = (kind == emmap_pkg::EMMAP_EMUL_RAM) || (kind == emmap_pkg::EMMAP_EMUL_ROM);
    assign is_rom   = (kind == emmap_pkg::EMMAP_EMUL_ROM) || (kind == emmap_pkg::EMMAP_TGT_ROM);
    // dma cycles take the same path as the processor's own
    assign guard_ev = cpu_cycle_in && (kind == emmap_pkg::EMMAP_GUARDED);
    assign romwr_ev = cpu_cycle_in && cpu_write_in && is_rom && rom_brk;

    // routing is combinational so the access finishes in its own bus cycle
    always_comb begin
        emem_sel_out     = cpu_cycle_in && is_emul;
        emem_write_out   = cpu_cycle_in && cpu_write_in && (kind == emmap_pkg::EMMAP_EMUL_RAM);
        emem_addr_out    = {emem_page, cpu_addr_in[9:0]};
        target_sel_out   = cpu_cycle_in && !is_emul;
        target_write_out = cpu_cycle_in && cpu_write_in && !is_emul;
        if (is_emul)
            cpu_ready_out = lock ? target_ready_in : 1'b1;
        else
            cpu_ready_out = target_ready_in;
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            break_req_out <= 1'b0;
        end else begin
            break_req_out <= guard_ev | romwr_ev;
        end
    end

    // map editing and monitor selection
    logic mon_change;
    logic clr_map;
    assign mon_change = do_wr && (avs_address_in == `EMMAP_MON_OFS)
                        && (avs_writedata_in[9:8] != mon[9:8]);
    assign clr_map = do_wr && (avs_address_in == `EMMAP_CTRL_OFS) && avs_writedata_in[`EMMAP_CTRL_CLRMAP];

    logic [9:0] next_alloc;
    logic [9:0] alloc;
    logic       map_edit;
    logic [9:0] new_len;
    assign new_len  = 10'(avs_writedata_in[19:10] - avs_writedata_in[9:0]);
    assign map_edit = do_wr && (avs_address_in == `EMMAP_ENTRY_OFS);

    always_comb begin
        next_alloc = alloc;
        if (map_edit && avs_writedata_in[`EMMAP_ENT_VALID]
            && avs_writedata_in[22:21] == 2'h0)
            next_alloc = 10'(alloc + new_len + 10'h001);
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < ENTRIES; i++) begin
                entry[i]    <= '0;
                blk_base[i] <= '0;
            end
            alloc <= '0;
        end else if (mon_change || clr_map) begin
            for (int i = 0; i < ENTRIES; i++) begin
                entry[i]    <= '0;
                blk_base[i] <= '0;
            end
            alloc <= '0;
            if (mon_change && avs_writedata_in[9:8] != 2'h0) begin
                // monitor gets four pages of emulation ram in entry 0
                entry[0].valid      <= 1'b1;
                entry[0].lock       <= avs_writedata_in[`EMMAP_MON_LOCK];
                entry[0].kind       <= emmap_pkg::EMMAP_EMUL_RAM;
                entry[0].start_page <= {avs_writedata_in[7:0], 2'h0};
                entry[0].end_page   <= {avs_writedata_in[7:0], 2'h3};
                blk_base[0]         <= '0;
                alloc               <= 10'h004;
            end
        end else if (map_edit && int'(sel) < ENTRIES) begin
            entry[sel].start_page <= avs_writedata_in[9:0];
            entry[sel].end_page   <= avs_writedata_in[19:10];
            entry[sel].kind       <= emmap_pkg::emmap_type_e'(avs_writedata_in[22:20]);
            entry[sel].lock       <= avs_writedata_in[`EMMAP_ENT_LOCK];
            entry[sel].valid      <= avs_writedata_in[`EMMAP_ENT_VALID];
            // simple bump allocation; any edit may move blocks
            blk_base[sel]         <= alloc;
            alloc                 <= next_alloc;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mon <= '0;
        end else if (do_wr && avs_address_in == `EMMAP_MON_OFS) begin
            mon <= avs_writedata_in[10:0];
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl <= 4'h0;
        end else if (do_wr && avs_address_in == `EMMAP_CTRL_OFS) begin
            ctrl <= {3'h0, avs_writedata_in[`EMMAP_CTRL_ROMBRK]};
        end
    end

    // a type code above guarded is refused and the old default kept
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dflt <= `EMMAP_DEF_RESET;
        end else if (do_wr && avs_address_in == `EMMAP_DEFAULT_OFS && avs_writedata_in[2:0] <= 3'h4) begin
            dflt <= avs_writedata_in[3:0];
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sel <= 4'h0;
        end else if (do_wr && avs_address_in == `EMMAP_SEL_OFS) begin
            sel <= avs_writedata_in[3:0];
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_en <= 4'h0;
        end else if (do_wr && avs_address_in == `EMMAP_IRQ_EN_OFS) begin
            irq_en <= avs_writedata_in[3:0];
        end
    end

    // recurring-break watch: a break within the window after each entry
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            loop_timer <= '0;
        end else if (monitor_entry_in) begin
            loop_timer <= 32'(LOOP_CYC);
        end else if (loop_timer != 32'h0) begin
            loop_timer <= loop_timer - 32'h1;
        end
    end

    // lockup is sticky: only reset releases it, so software always sees it
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            loop_hits  <= '0;
            lockup_out <= 1'b0;
        end else if (break_req_out && loop_timer != 32'h0) begin
            if (loop_hits == 3'(`EMMAP_LOOP_LIMIT - 1))
                lockup_out <= 1'b1;
            else
                loop_hits <= 3'(loop_hits + 3'h1);
        end else if (!monitor_entry_in && loop_timer == 32'h1) begin
            loop_hits <= '0;
        end
    end

    // sticky status: a new event wins over a clear in the same cycle
    logic [3:0] ev;
    logic [3:0] clr;
    assign ev  = {map_edit | mon_change | clr_map, lockup_out, romwr_ev, guard_ev};
    assign clr = (do_wr && avs_address_in == `EMMAP_IRQ_CLR_OFS) ? avs_writedata_in[3:0] : 4'h0;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status <= 4'h0;
        end else begin
            status <= (status & ~clr) | ev;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            break_count <= '0;
        end else if (break_req_out) begin
            break_count <= break_count + 32'h1;
        end
    end

    assign irq_out = |(status & irq_en);

    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0;
        case (avs_address_in)
            `EMMAP_CTRL_OFS:    rdata = {28'h0, ctrl};
            `EMMAP_DEFAULT_OFS: rdata = {28'h0, dflt};
            `EMMAP_MON_OFS:     rdata = {21'h0, mon};
            `EMMAP_STATUS_OFS:  rdata = {28'h0, status};
            `EMMAP_IRQ_EN_OFS:  rdata = {28'h0, irq_en};
            `EMMAP_SEL_OFS:     rdata = {28'h0, sel};
            `EMMAP_ENTRY_OFS:   rdata = (int'(sel) < ENTRIES) ? {7'h0, entry[sel]} : 32'h0;
            `EMMAP_ALLOC_OFS:   rdata = {22'h0, alloc};
            `EMMAP_BREAK_OFS:   rdata = break_count;
            default:            rdata = 32'h0;
        endcase
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            avs_readdata_out <= 32'h0;
        end else if (avs_read_in && !rd_ack) begin
            avs_readdata_out <= rdata;
        end
    end
endmodule
